//--- dcl_ctrl_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// controller model driving the command pins
// ****************************************
module dcl_ctrl_model (
	input wire logic mclk, // command clock
	input wire logic desel, // high: chip not selected
	input wire dcl_pkg::dcl_op_type op, // command to encode
	input wire logic [dcl_pkg::dcl_ba_w-1:0] ba, // target bank
	input wire logic a10, // precharge all banks flag
	input wire logic cke, // wanted clock enable level
	output var dcl_pkg::dcl_cmd_type cmd_pin, // command pins
	output var logic cke_pin // clock enable pin
);
	import dcl_pkg::*;
	logic [12:0] junk = 13'h0; // free-running filler for address bits
	// ras, cas, we for each command
	function automatic logic [2:0] enc_of(input dcl_op_type o);
		case (o)
			dcl_op_bst: return 3'h6;
			dcl_op_rd: return 3'h5;
			dcl_op_wr: return 3'h4;
			dcl_op_act: return 3'h3;
			dcl_op_pre: return 3'h2;
			dcl_op_ref: return 3'h1;
			dcl_op_mrs: return 3'h0;
			default: return 3'h7; // no-operation
		endcase
	endfunction
	initial cmd_pin = '1;
	initial cke_pin = 1'b1;
	// pins change just after the edge and hold one cycle
	always @(posedge mclk) begin
		junk <= junk + 13'h1;
		cke_pin <= cke;
		if (desel) begin
			// deselected: lines show a changing pattern, not the last value
			cmd_pin <= {1'b1, ~cmd_pin[17:0]};
		end else begin
			// no data bus modelled, so burst spacing cannot be broken
			cmd_pin <= {1'b0, enc_of(op), ba, junk[12:11], a10, junk[9:0]};
		end
	end
endmodule // dcl_ctrl_model
`default_nettype wire

//--- dcl_legality.sv
`timescale 1ns/1ps
`default_nettype none
module dcl_legality (
	input wire logic mclk, // command clock
	input wire logic srst, // synchronous reset, high
	input wire logic ce, // clock enable for all state
	input wire logic cke_pin, // dram clock enable pin
	input wire dcl_pkg::dcl_cmd_type cmd_pin, // command pins
	output logic illegal, // one-cycle protocol error pulse
	output logic all_idle, // every bank idle
	output logic low_power, // self refresh or power down
	output logic [2:0] dev_state // device-wide state code
);
	import dcl_pkg::*;

	// ****************************************
	// pin synchronisers
	// ****************************************
	logic cke_s1, cke_s2, cke_prev; // enable sync chain and previous
	dcl_cmd_type cmd_s1, cmd_s2; // command sync chain
	// two stages; first stage read only by second
	always_ff @(posedge mclk) begin
		if (srst) begin
			cke_s1 <= 1'b1;
			cke_s2 <= 1'b1;
			cke_prev <= 1'b1;
			cmd_s1 <= '1;
			cmd_s2 <= '1;
		end else if (ce) begin
			cke_s1 <= cke_pin;
			cke_s2 <= cke_s1;
			cke_prev <= cke_s2;
			cmd_s1 <= cmd_pin;
			cmd_s2 <= cmd_s1;
		end
	end

	// ****************************************
	// command decode
	// ****************************************
	wire [2:0] rcw = {cmd_s2.ras_n, cmd_s2.cas_n, cmd_s2.we_n}; // encoding
	dcl_op_type op; // decoded command
	always_comb begin
		if (cmd_s2.cs_n) op = dcl_op_nop;
		else begin
			case (rcw)
				3'h7: op = dcl_op_nop;
				3'h6: op = dcl_op_bst;
				3'h5: op = dcl_op_rd;
				3'h4: op = dcl_op_wr;
				3'h3: op = dcl_op_act;
				3'h2: op = dcl_op_pre;
				3'h1: op = dcl_op_ref;
				default: op = dcl_op_mrs;
			endcase
		end
	end
	wire both_high = cke_prev & cke_s2; // state decode applies
	wire cke_fall = cke_prev & ~cke_s2; // low-power entry edge
	wire cke_rise = ~cke_prev & cke_s2; // low-power exit edge
	wire pre_all = cmd_s2.addr[dcl_ap_bit]; // precharge all banks

	// ****************************************
	// per-bank state and legality
	// ****************************************
	dcl_bank_type bank [dcl_banks]; // bank states
	logic [dcl_cnt_w-1:0] bcnt [dcl_banks]; // bank timers
	logic [dcl_banks-1:0] bad_bank; // bank rejects op: the addressed bank, or any bank on a precharge-all
	logic [dcl_banks-1:0] bank_idle; // idle flags
	dcl_dev_type dev; // device state
	logic [dcl_cnt_w-1:0] dcnt; // device timer
	wire dev_busy = (dev != dcl_d_normal); // no bank command accepted
	wire go = ce & both_high & ~dev_busy; // bank commands live [R9]

	genvar g;
	generate
		for (g = 0; g < dcl_banks; g++) begin : gb
			wire hit = (cmd_s2.ba == dcl_ba_w'(g)); // addressed bank
			wire pre_me = (op == dcl_op_pre) & (hit | pre_all); // precharge reaches it
			assign bank_idle[g] = (bank[g] == dcl_b_idle);
			// the addressed bank judges the command; every bank judges a precharge-all
			always_comb begin
				bad_bank[g] = 1'b0; // [R1]
				case (bank[g])
					dcl_b_prechg: bad_bank[g] = hit & (op inside {dcl_op_bst,
						dcl_op_rd, dcl_op_wr, dcl_op_act}); // [R2]
					dcl_b_act_wait: bad_bank[g] = (hit & (op inside {dcl_op_bst,
						dcl_op_rd, dcl_op_wr, dcl_op_act})) | pre_me; // [R3]
					dcl_b_wr_rec: bad_bank[g] = (hit & (op inside {dcl_op_bst,
						dcl_op_rd, dcl_op_act})) | pre_me; // [R4]
					dcl_b_idle: bad_bank[g] = hit & (op inside {dcl_op_bst,
						dcl_op_rd, dcl_op_wr});
					dcl_b_active: bad_bank[g] = hit & (op == dcl_op_act);
					default: bad_bank[g] = 1'b0;
				endcase
			end
			// bank transitions with their timers
			always_ff @(posedge mclk) begin
				if (srst) begin
					bank[g] <= dcl_b_idle;
					bcnt[g] <= '0;
				end else if (ce) begin
					if (bcnt[g] != '0) bcnt[g] <= bcnt[g] - 1'b1;
					case (bank[g])
						dcl_b_prechg: if (bcnt[g] <= 1) bank[g] <= dcl_b_idle; // [R2]
						dcl_b_act_wait: if (bcnt[g] <= 1) bank[g] <= dcl_b_active; // [R3]
						dcl_b_wr_rec: begin
							if (go & hit & op == dcl_op_wr) begin
								bcnt[g] <= dcl_cnt_w'(dcl_wr_cyc); // [R4]
							end else if (bcnt[g] <= 1) begin
								bank[g] <= dcl_b_active;
							end
						end
						dcl_b_idle: if (go & hit & op == dcl_op_act) begin
							bank[g] <= dcl_b_act_wait;
							bcnt[g] <= dcl_cnt_w'(dcl_rcd_cyc);
						end
						dcl_b_active: begin
							if (go & pre_me) begin
								bank[g] <= dcl_b_prechg;
								bcnt[g] <= dcl_cnt_w'(dcl_precharge_cyc);
							end else if (go & hit & op == dcl_op_wr) begin
								bank[g] <= dcl_b_wr_rec;
								bcnt[g] <= dcl_cnt_w'(dcl_wr_cyc);
							end
						end
						default: bank[g] <= dcl_b_idle;
					endcase
				end
			end
		end
	endgenerate

	// ****************************************
	// device-wide legality
	// ****************************************
	wire idle_all = &bank_idle; // all banks idle
	wire quiet = (op == dcl_op_nop); // deselect or no-op
	wire need_idle = (op == dcl_op_ref) | (op == dcl_op_mrs); // [R11]
	wire ill_norm = (|bad_bank) | (need_idle & ~idle_all); // [R11]
	wire ill_busy = ~quiet; // [R5]
	wire ill_entry = ~idle_all | ~(quiet | op == dcl_op_ref); // [R8]
	logic bad_now; // combined error this cycle
	always_comb begin
		bad_now = 1'b0;
		case (dev)
			dcl_d_normal: bad_now = both_high ? ill_norm : (cke_fall & ill_entry); // [R9]
			dcl_d_refresh, dcl_d_mode: bad_now = both_high & ill_busy; // [R5]
			dcl_d_self: bad_now = cke_rise & ~quiet; // [R6]
			dcl_d_sr_exit, dcl_d_pd_exit: bad_now = ~quiet; // [R6]
			default: bad_now = 1'b0; // [R7]
		endcase
	end

	// device transitions
	always_ff @(posedge mclk) begin
		if (srst) begin
			dev <= dcl_d_normal;
			dcnt <= '0;
			illegal <= 1'b0;
		end else if (ce) begin
			illegal <= bad_now; // [R12]
			if (dcnt != '0) dcnt <= dcnt - 1'b1;
			case (dev)
				dcl_d_normal: begin
					if (cke_fall & idle_all & op == dcl_op_ref) begin
						dev <= dcl_d_self; // [R8]
					end else if (cke_fall & idle_all & quiet) begin
						dev <= dcl_d_pdown; // [R8]
					end else if (go & idle_all & op == dcl_op_ref) begin
						dev <= dcl_d_refresh;
						dcnt <= dcl_cnt_w'(dcl_rfc_cyc);
					end else if (go & idle_all & op == dcl_op_mrs) begin
						dev <= dcl_d_mode;
						dcnt <= dcl_cnt_w'(dcl_mrd_cyc);
					end
				end
				dcl_d_refresh, dcl_d_mode: if (dcnt <= 1) dev <= dcl_d_normal; // [R5]
				dcl_d_self: if (cke_rise) begin
					dev <= dcl_d_sr_exit; // [R6]
					dcnt <= dcl_cnt_w'(dcl_srex_cyc);
				end
				dcl_d_pdown: if (cke_rise) begin
					dev <= dcl_d_pd_exit; // [R7]
					dcnt <= dcl_cnt_w'(dcl_pdex_cyc);
				end
				dcl_d_sr_exit, dcl_d_pd_exit: if (dcnt <= 1) dev <= dcl_d_normal;
				default: dev <= dcl_d_normal;
			endcase
		end
	end

	// ****************************************
	// outputs
	// ****************************************
	assign all_idle = idle_all;
	assign low_power = (dev == dcl_d_self) | (dev == dcl_d_pdown);
	assign dev_state = dev;

	// ****************************************
	// assertions
	// ****************************************
	refresh_needs_idle_a: assert property (@(posedge mclk) disable iff (srst) // [R11]
		ce & both_high & (dev == dcl_d_normal) & (op == dcl_op_ref) & ~idle_all |=> illegal)
		else $error("refresh with open bank not flagged");
	pd_entry_a: assert property (@(posedge mclk) disable iff (srst) // [R8]
		ce & (dev == dcl_d_normal) & cke_fall & idle_all & quiet |=> dev == dcl_d_pdown)
		else $error("power down not entered");
	sr_entry_a: assert property (@(posedge mclk) disable iff (srst) // [R8]
		ce & (dev == dcl_d_normal) & cke_fall & idle_all & op == dcl_op_ref
		|=> dev == dcl_d_self)
		else $error("self refresh not entered");
	pd_exit_a: assert property (@(posedge mclk) disable iff (srst) // [R7]
		ce & (dev == dcl_d_pdown) & cke_rise |=> dev == dcl_d_pd_exit)
		else $error("power down not exited");
	pd_hold_a: assert property (@(posedge mclk) disable iff (srst) // [R7]
		ce & (dev == dcl_d_pdown) & ~cke_rise |=> dev == dcl_d_pdown)
		else $error("power down left without enable rise");
	sr_quiet_a: assert property (@(posedge mclk) disable iff (srst) // [R6]
		ce & (dev == dcl_d_sr_exit) & ~quiet |=> illegal)
		else $error("command during self refresh exit not flagged");
	busy_quiet_a: assert property (@(posedge mclk) disable iff (srst) // [R5]
		ce & both_high & (dev == dcl_d_refresh) & ~quiet |=> illegal)
		else $error("command during refresh not flagged");
	prechg_idle_a: assert property (@(posedge mclk) disable iff (srst) // [R2]
		ce & (bank[0] == dcl_b_prechg) & (bcnt[0] <= 1) |=> bank[0] == dcl_b_idle)
		else $error("bank not idle after precharge period");
	rcd_block_a: assert property (@(posedge mclk) disable iff (srst) // [R3]
		ce & go & (bank[0] == dcl_b_act_wait) & (cmd_s2.ba == 2'h0) & op == dcl_op_rd
		|=> illegal)
		else $error("read inside row to column delay not flagged");
	wr_rec_a: assert property (@(posedge mclk) disable iff (srst) // [R4]
		ce & go & (bank[0] == dcl_b_wr_rec) & (cmd_s2.ba == 2'h0) & op == dcl_op_wr
		|=> bank[0] == dcl_b_wr_rec)
		else $error("write in recovery not accepted");
	no_decode_a: assert property (@(posedge mclk) disable iff (srst) // [R9]
		ce & (dev == dcl_d_normal) & ~cke_prev |=> ~illegal)
		else $error("decode used with enable low");
	// a low enable must hold the device state, the error flag and the bank 0 state
	ce_freeze_a: assert property (@(posedge mclk) disable iff (srst)
		~ce |=> (dev == $past(dev)) && (illegal == $past(illegal)) && (bank[0] == $past(bank[0])))
		else $error("state moved while clock enable low");
	sr_cov: cover property (@(posedge mclk) dev == dcl_d_self ##1 dev == dcl_d_sr_exit);
	pd_cov: cover property (@(posedge mclk) dev == dcl_d_pdown ##1 dev == dcl_d_pd_exit);
	ill_cov: cover property (@(posedge mclk) illegal);
	ref_cov: cover property (@(posedge mclk) dev == dcl_d_refresh);
endmodule // dcl_legality
`default_nettype wire

//--- dcl_pkg.sv
// Functional notes
// [R1] illegal marking concerns only the addressed bank; the code has every bank judge a precharge-all
// [R2] precharge on precharging or idle bank: no-op
// [R3] no commands to bank before row-to-column delay
// [R4] write recovery window accepts only a new write
// [R5] refresh or mode set busy: deselect/nop only
// [R6] self refresh exit: nop until exit setup
// [R7] clock enable rise exits power down, idle later
// [R8] low-power entry only with all banks idle
// [R9] state decode only when enable high twice
// [R10] burst interrupt spacing kept by the controller
// [R11] refresh and mode set need all banks idle
// [R12] illegal commands flagged as protocol errors
package dcl_pkg;
	// ****************************************
	// timing, given in ns and converted to counts in command clock cycles
	// ****************************************
	localparam int dcl_clk_period_ns = 50;
	localparam int dcl_precharge_period_ns = 20;
	localparam int dcl_row_to_column_delay_ns = 20;
	localparam int dcl_write_recovery_time_ns = 15;
	localparam int dcl_refresh_cycle_ns = 75;
	localparam int dcl_mode_set_ns = 15;
	localparam int dcl_pd_exit_ns = 10;
	localparam int dcl_sr_exit_ns = 200;
	// least times round up, floor of one cycle
	function automatic int dcl_cyc(input int ns);
		int c;
		c = (ns + dcl_clk_period_ns - 1) / dcl_clk_period_ns;
		return (c < 1) ? 1 : c;
	endfunction
	localparam int dcl_precharge_cyc = dcl_cyc(dcl_precharge_period_ns);
	localparam int dcl_rcd_cyc = dcl_cyc(dcl_row_to_column_delay_ns);
	localparam int dcl_wr_cyc = dcl_cyc(dcl_write_recovery_time_ns);
	localparam int dcl_rfc_cyc = dcl_cyc(dcl_refresh_cycle_ns);
	localparam int dcl_mrd_cyc = dcl_cyc(dcl_mode_set_ns);
	localparam int dcl_pdex_cyc = dcl_cyc(dcl_pd_exit_ns);
	localparam int dcl_srex_cyc = dcl_cyc(dcl_sr_exit_ns);
	localparam int dcl_cnt_w = 8;
	localparam int dcl_banks = 4;
	localparam int dcl_ba_w = 2;
	localparam int dcl_ap_bit = 10;
	localparam int dcl_addr_w = 13;
	// ****************************************
	// command pin group
	// ****************************************
	typedef struct packed {
		logic cs_n;
		logic ras_n;
		logic cas_n;
		logic we_n;
		logic [dcl_ba_w-1:0] ba;
		logic [dcl_addr_w-1:0] addr;
	} dcl_cmd_type;
	typedef enum logic [2:0] {
		dcl_op_nop, dcl_op_bst, dcl_op_rd, dcl_op_wr,
		dcl_op_act, dcl_op_pre, dcl_op_ref, dcl_op_mrs
	} dcl_op_type;
	// per-bank transient state
	typedef enum logic [2:0] {
		dcl_b_idle, dcl_b_prechg, dcl_b_act_wait, dcl_b_active, dcl_b_wr_rec
	} dcl_bank_type;
	// device-wide state
	typedef enum logic [2:0] {
		dcl_d_normal, dcl_d_refresh, dcl_d_mode, dcl_d_self, dcl_d_sr_exit,
		dcl_d_pdown, dcl_d_pd_exit
	} dcl_dev_type;
endpackage

//--- tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import dcl_pkg::*;
	logic mclk = 1'b0; // command clock
	logic srst = 1'b1; // reset, held at start
	logic desel = 1'b1; // model idle
	logic a10 = 1'b0; // all-banks flag
	logic cke = 1'b1; // wanted clock enable
	logic ce = 1'b1; // design clock enable, dropped while idle
	dcl_op_type op = dcl_op_nop; // next command
	logic [1:0] ba = 2'h0; // next bank
	dcl_cmd_type cmd_pin; // pins to the design
	logic cke_pin, illegal, all_idle, low_power;
	logic [2:0] dev_state;
	int errors = 0, n_compared = 0, n_ill = 0, base = 0, cyc = 0;
	logic [1:0] b, o;
	dcl_ctrl_model i_dcl_ctrl_model (.mclk(mclk), .desel(desel), .op(op), .ba(ba), .a10(a10),
		.cke(cke), .cmd_pin(cmd_pin), .cke_pin(cke_pin));
	// ce drops for two cycles at the end of each case, pins quiet then
	dcl_legality i_dcl_legality (.mclk(mclk), .srst(srst), .ce(ce), .cke_pin(cke_pin),
		.cmd_pin(cmd_pin), .illegal(illegal), .all_idle(all_idle), .low_power(low_power),
		.dev_state(dev_state));
	initial forever #25 mclk = ~mclk;
	// ****************************************
	// pulse counter and hang guard
	// ****************************************
	always @(posedge mclk) begin
		cyc++;
		if (illegal === 1'b1) n_ill++;
		if (cyc == 5000) begin
			errors++;
			complete_run();
		end
	end
	task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
		n_compared++;
		if (seen !== exp) begin
			errors++;
			$display("ERROR %s expected %0h seen %0h", name, exp, seen);
		end
	endtask
	task automatic complete_run();
		$display("compared %0d errors %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	// one command for one cycle
	task automatic send(input dcl_op_type c, input logic [1:0] k_b, input logic a, input logic k);
		@(posedge mclk);
		desel <= 1'b0;
		op <= c;
		ba <= k_b;
		a10 <= a;
		cke <= k;
	endtask
	task automatic idle(input int n, input logic k);
		repeat (n) begin
			@(posedge mclk);
			desel <= 1'b1;
			cke <= k;
		end
	endtask
	// short reset so each case starts from all banks idle
	task automatic fresh();
		@(posedge mclk);
		srst <= 1'b1;
		idle(2, 1'b1);
		srst <= 1'b0;
		@(negedge mclk);
		base = n_ill;
	endtask
	// let the pipeline drain, then count protocol error pulses
	task automatic finish_case(input string name, input int exp, input logic k);
		idle(6, k);
		ce <= 1'b0;
		idle(2, k);
		ce <= 1'b1;
		idle(2, k);
		@(negedge mclk);
		check(name, 8'(n_ill - base), 8'(exp));
	endtask
	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		b = 2'($urandom(72));
		repeat (8) @(posedge mclk);
		srst <= 1'b0;
		@(negedge mclk);
		check("reset_state", {illegal, all_idle, low_power, 2'h0, dev_state}, 8'h40);
		for (int i = 0; i < 4; i++) begin
			// bank 0 first, so the bank-0 assertions see traffic
			b = (i == 0) ? 2'h0 : 2'($urandom);
			o = b + 2'($urandom % 3) + 2'h1;
			fresh();
			send(dcl_op_act, b, 1'b0, 1'b1);
			send(dcl_op_rd, b, 1'b0, 1'b1);
			finish_case("act_read", 1, 1'b1);
			fresh();
			send(dcl_op_act, b, 1'b0, 1'b1);
			send(dcl_op_act, o, 1'b0, 1'b1);
			finish_case("act_other", 0, 1'b1);
			check("busy_banks", 8'(all_idle), 8'h0);
			fresh();
			send(dcl_op_pre, b, 1'($urandom), 1'b1);
			finish_case("pre_idle", 0, 1'b1);
			fresh();
			send(dcl_op_act, b, 1'b0, 1'b1);
			idle(3, 1'b1);
			send(dcl_op_pre, o, 1'b1, 1'b1);
			send(dcl_op_pre, b, 1'b0, 1'b1);
			finish_case("pre_all", 0, 1'b1);
			check("idle_after_pre", 8'(all_idle), 8'h1);
			fresh();
			send(dcl_op_act, b, 1'b0, 1'b1);
			idle(3, 1'b1);
			send(dcl_op_wr, b, 1'b0, 1'b1);
			send(dcl_op_wr, b, 1'b0, 1'b1);
			finish_case("wr_wr", 0, 1'b1);
			fresh();
			send(dcl_op_act, b, 1'b0, 1'b1);
			idle(3, 1'b1);
			send(dcl_op_wr, b, 1'b0, 1'b1);
			send(dcl_op_rd, b, 1'b0, 1'b1);
			finish_case("wr_rd", 1, 1'b1);
			fresh();
			send(dcl_op_ref, b, 1'b0, 1'b1);
			send(dcl_op_act, b, 1'b0, 1'b1);
			finish_case("ref_act", 1, 1'b1);
			fresh();
			send(dcl_op_mrs, b, 1'b0, 1'b1);
			send(dcl_op_ref, b, 1'b0, 1'b1);
			finish_case("mrs_ref", 1, 1'b1);
			fresh();
			send(dcl_op_act, b, 1'b0, 1'b1);
			idle(3, 1'b1);
			send(dcl_op_ref, o, 1'b0, 1'b1);
			finish_case("ref_busy", 1, 1'b1);
			// power down: garbage while low, exit whatever the command
			fresh();
			send(dcl_op_nop, b, 1'b0, 1'b0);
			idle(4, 1'b0);
			send(dcl_op_act, b, 1'b0, 1'b0);
			idle(2, 1'b0);
			@(negedge mclk);
			check("pdown_state", {low_power, 4'h0, dev_state}, 8'h85);
			send(dcl_op_rd, b, 1'b0, 1'b1);
			finish_case("pdown_exit", 0, 1'b1);
			check("pdown_idle", {low_power, 4'h0, dev_state}, 8'h00);
			// self refresh: exit with a read, then a command in the exit window
			fresh();
			send(dcl_op_ref, b, 1'b0, 1'b0);
			idle(4, 1'b0);
			@(negedge mclk);
			check("self_state", {low_power, 4'h0, dev_state}, 8'h83);
			send(dcl_op_rd, b, 1'b0, 1'b1);
			send(dcl_op_act, o, 1'b0, 1'b1);
			idle(12, 1'b1);
			finish_case("self_exit", 2, 1'b1);
			check("self_idle", {low_power, 4'h0, dev_state}, 8'h00);
			fresh();
			send(dcl_op_act, b, 1'b0, 1'b0);
			finish_case("entry_bad_cmd", 1, 1'b1);
			fresh();
			send(dcl_op_act, b, 1'b0, 1'b1);
			idle(3, 1'b1);
			send(dcl_op_nop, b, 1'b0, 1'b0);
			finish_case("entry_busy", 1, 1'b1);
		end
		complete_run();
	end
endmodule // tb_top
`default_nettype wire
